/* design/supply_monitor_pkg.sv */
// Constants shared by the supply monitor control logic
package supply_monitor_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [15:0] CTRL_ADDR = 16'hffbe;
	localparam logic [15:0] LEVEL_ADDR = 16'hffbf;
	localparam logic [15:0] CAUSE_ADDR = 16'hffab;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ENABLE_BIT = 7;
	localparam int MODE_BIT = 1;
	localparam int FLAG_BIT = 0;
	localparam int CAUSE_BIT = 0;
	localparam int LEVEL_MSB = 3;

	// ------------------------------------------------------------
	// Reset values and the default-start level
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] LEVEL_RESET = 8'h00;
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	localparam logic [3:0] LOWEST_LEVEL = 4'hf;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int MIN_PULSE_US = 200;
	// Least time: round up to whole cycles
	localparam int MIN_PULSE_CYCLES =
		(MIN_PULSE_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

/* design/supply_monitor_control.sv */
// Control and status logic of the on-chip supply level monitor
//
// Functional notes
// R1: Reset mode holds reset while supply is below threshold, releases above.
// R2: Interrupt mode: one interrupt per threshold crossing, both directions.
// R3: Mode-select bit is bit 1 of the control register; 1 means reset.
// R4: Enable bit starts comparator when 1, stops detection when 0. With the default-start option, 0 keeps detection on at the lowest level.
// R5: Read-only bit 0 flag is 1 while below threshold; 0 above or disabled.
// R6: Flag sets only after supply stays low for the minimum pulse width.
// R7: After enabling, software waits out comparator settling before use.
// R8: A monitor reset sets bit 0 of the reset-cause register.
// R9: Other resets clear control; monitor reset keeps it unless default-start.
// R10: Level-select survives monitor reset except default-start; else clears.
// R11: Four-bit level code picks one of 16 thresholds; 0 is highest.
// R12: Software stops the monitor by writing 00 or clearing just enable. With the default-start option, the monitor keeps running instead.
// R13: Disabling in interrupt mode while below threshold raises an interrupt.
// R14: Detection, reset and interrupt keep working in STOP mode.
// R15: Default-start: on from power-up at lowest level, reset while below.
// R16: Both registers accept single-bit and full-byte writes.
// R17: Software keeps level-select bits 7 to 4 at zero.
// R18: Software leaves level-select unchanged while the monitor runs.
// R19: Comparator output is synchronised before any use.
// R20: Interrupt is one pulse per crossing, not a held level.
`timescale 1ns/1ps

module supply_monitor_control
	import supply_monitor_pkg::*;
#(
	parameter int MIN_PULSE_CNT = MIN_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// System reset logic
	input wire logic other_reset_in,
	input wire logic default_start_option_in,
	output logic monitor_reset_out,
	// Analog comparator
	input wire logic below_threshold_in,
	output logic comparator_enable_out,
	output logic [3:0] level_code_out,
	// Interrupt
	output logic monitor_interrupt_request_out,
	// CPU register access
	input wire logic [15:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_bit_op_in,
	input wire logic [2:0] reg_bit_sel_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out
);

	// ------------------------------------------------------------
	// Write merge
	// ------------------------------------------------------------
	// Bit write takes its value from wdata bit 0
	function automatic logic [7:0] merge_write(
		input logic [7:0] old_val,
		input logic [7:0] wdata,
		input logic bit_op,
		input logic [2:0] bit_sel
	);
		logic [7:0] res;
		res = old_val;
		if (bit_op) begin
			res[bit_sel] = wdata[0]; // [R16]
		end else begin
			res = wdata; // [R16]
		end
		return res;
	endfunction

	logic comp_meta_reg;
	logic comp_sync_reg;
	logic option_meta_reg;
	logic option_sync_reg;
	logic enable_reg;
	logic mode_reg;
	logic [3:0] level_reg;
	logic cause_reg;
	logic flag_reg;
	logic flag_next;
	logic [15:0] pulse_cnt_reg;
	logic [15:0] pulse_cnt_next;
	logic irq_reg;
	logic mon_rst_reg;
	logic ds_rst_reg;
	logic comp_en_reg;
	logic [3:0] level_out_reg;
	logic [7:0] rdata_reg;
	logic default_active;
	logic detect_on;
	logic ctrl_wr;
	logic level_wr;
	logic [7:0] ctrl_view;
	logic [7:0] ctrl_new;
	logic [7:0] level_new;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			comp_meta_reg <= 1'b0;
			comp_sync_reg <= 1'b0;
		end else begin
			comp_meta_reg <= below_threshold_in; // [R19]
			comp_sync_reg <= comp_meta_reg; // [R19]
		end
	end

	// Strap caught after release, not under the reset
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			option_meta_reg <= 1'b0;
			option_sync_reg <= 1'b0;
		end else begin
			option_meta_reg <= default_start_option_in;
			option_sync_reg <= option_meta_reg;
		end
	end

	// Default-start keeps the comparator on until software takes over
	assign default_active = option_sync_reg & ~enable_reg; // [R15]
	assign detect_on = enable_reg | default_active; // [R4]

	// ------------------------------------------------------------
	// Pulse-width filter and level flag
	// ------------------------------------------------------------
	always_comb begin
		pulse_cnt_next = pulse_cnt_reg;
		flag_next = flag_reg;
		if (!detect_on || !comp_sync_reg) begin
			pulse_cnt_next = 16'h0000; // [R5]
			flag_next = 1'b0; // [R5]
		end else if (pulse_cnt_reg < 16'(MIN_PULSE_CNT - 1)) begin
			pulse_cnt_next = pulse_cnt_reg + 16'h0001; // [R6]
		end else begin
			flag_next = 1'b1; // [R6]
		end
	end

	// No clock gating here: the block runs on in STOP mode [R14]
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pulse_cnt_reg <= 16'h0000;
			flag_reg <= 1'b0;
		end else begin
			pulse_cnt_reg <= pulse_cnt_next;
			flag_reg <= flag_next;
		end
	end

	// ------------------------------------------------------------
	// Interrupt and reset generation
	// ------------------------------------------------------------
	// Flag falling on disable also counts as a crossing
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (flag_next != flag_reg) && !mode_reg
				&& !default_active; // [R2] [R13] [R20]
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mon_rst_reg <= 1'b0;
			ds_rst_reg <= 1'b0;
		end else begin
			mon_rst_reg <= flag_next
				&& ((enable_reg && mode_reg) || default_active); // [R1] [R15]
			ds_rst_reg <= flag_next && default_active; // [R15]
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	assign ctrl_wr = reg_wr_in && (reg_addr_in == CTRL_ADDR);
	assign level_wr = reg_wr_in && (reg_addr_in == LEVEL_ADDR);

	always_comb begin
		ctrl_view = CTRL_RESET;
		ctrl_view[ENABLE_BIT] = enable_reg;
		ctrl_view[MODE_BIT] = mode_reg; // [R3]
		ctrl_view[FLAG_BIT] = flag_reg; // [R5]
	end

	assign ctrl_new = merge_write(ctrl_view, reg_wdata_in, reg_bit_op_in,
		reg_bit_sel_in);
	assign level_new = merge_write({4'h0, level_reg}, reg_wdata_in,
		reg_bit_op_in, reg_bit_sel_in);

	// Writes are ignored while the CPU is held in monitor reset
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			enable_reg <= CTRL_RESET[ENABLE_BIT];
			mode_reg <= CTRL_RESET[MODE_BIT];
			level_reg <= LEVEL_RESET[LEVEL_MSB:0];
		end else if (other_reset_in || ds_rst_reg) begin
			enable_reg <= CTRL_RESET[ENABLE_BIT]; // [R9]
			mode_reg <= CTRL_RESET[MODE_BIT]; // [R9]
			level_reg <= LEVEL_RESET[LEVEL_MSB:0]; // [R10]
		end else if (!mon_rst_reg) begin
			if (ctrl_wr) begin
				enable_reg <= ctrl_new[ENABLE_BIT]; // [R4]
				mode_reg <= ctrl_new[MODE_BIT]; // [R3]
			end
			if (level_wr) begin
				level_reg <= level_new[LEVEL_MSB:0]; // [R11]
			end
		end
	end

	// Reading the cause register clears it; a new monitor reset wins
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cause_reg <= CAUSE_RESET[CAUSE_BIT];
		end else if (mon_rst_reg) begin
			cause_reg <= 1'b1; // [R8]
		end else if (other_reset_in) begin
			cause_reg <= CAUSE_RESET[CAUSE_BIT];
		end else if (reg_rd_in && (reg_addr_in == CAUSE_ADDR)) begin
			cause_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			comp_en_reg <= 1'b0;
			level_out_reg <= LEVEL_RESET[LEVEL_MSB:0];
		end else begin
			comp_en_reg <= detect_on; // [R4]
			level_out_reg <= default_active ? LOWEST_LEVEL
				: level_reg; // [R11] [R15]
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				CTRL_ADDR: rdata_reg <= ctrl_view;
				LEVEL_ADDR: rdata_reg <= {4'h0, level_reg};
				CAUSE_ADDR: rdata_reg <= {7'h00, cause_reg};
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	assign monitor_reset_out = mon_rst_reg;
	assign monitor_interrupt_request_out = irq_reg;
	assign comparator_enable_out = comp_en_reg;
	assign level_code_out = level_out_reg;
	assign reg_rdata_out = rdata_reg;

endmodule

/* bench/supply_comparator_model.sv */
// Behavioural supply comparator facing the monitor control block
`timescale 1ns/1ps
module supply_comparator_model (
	// From the monitor
	input wire logic enable_in,
	input wire logic [3:0] level_in,
	// Supply as a threshold code, larger means lower voltage
	input wire logic [4:0] supply_in,
	// To the monitor
	output logic below_out
);
	// An idle comparator never reports low; equal level counts as above
	assign below_out = enable_in && (supply_in > {1'b0, level_in});
endmodule

/* bench/supply_monitor_control_properties.sv */
// Port-level checks for the supply monitor control block
`timescale 1ns/1ps
module supply_monitor_control_properties
	import supply_monitor_pkg::*;
#(
	parameter int MIN_PULSE_CNT = 8
) (
	// Watched ports
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic other_reset_in,
	input wire logic below_threshold_in,
	input wire logic comparator_enable_out,
	input wire logic monitor_reset_out,
	input wire logic monitor_interrupt_request_out,
	input wire logic [15:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	wire irq = monitor_interrupt_request_out;
	wire ctrl_rd = reg_rd_in && reg_addr_in == CTRL_ADDR;
	logic [15:0] low_cnt;
	// Run length of the raw level, saturating so it never wraps
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			low_cnt <= 16'h0;
		else if (!below_threshold_in)
			low_cnt <= 16'h0;
		else if (low_cnt != 16'hffff)
			low_cnt <= low_cnt + 16'h1;
	end
	chk_irq_one_pulse: assert property (irq |=> !irq)
		else $error("interrupt too long");
	chk_irq_not_rst: assert property (irq |-> !monitor_reset_out)
		else $error("interrupt in reset");
	chk_rst_min_wait: assert property (
		$rose(monitor_reset_out) |-> low_cnt >= MIN_PULSE_CNT)
		else $error("reset too early");
	chk_rst_release: assert property (
		(!below_threshold_in) [*4] |=> !monitor_reset_out)
		else $error("reset held above threshold");
	// Comparator passes two flops, so it must stand low three samples
	chk_rst_held: assert property (
		(below_threshold_in && !other_reset_in)
		##1 (below_threshold_in && !other_reset_in
		&& monitor_reset_out) [*2]
		|=> monitor_reset_out)
		else $error("reset dropped while low");
	chk_off_no_rst: assert property (
		(!comparator_enable_out) [*4] |-> !monitor_reset_out)
		else $error("reset while off");
	chk_level_upper: assert property (
		reg_rd_in && reg_addr_in == LEVEL_ADDR
		|=> reg_rdata_out[7:4] == 4'h0)
		else $error("level upper bits set");
	chk_flag_off: assert property (
		(!comparator_enable_out) [*4] ##0 ctrl_rd
		|=> !reg_rdata_out[FLAG_BIT])
		else $error("flag set while off");
	cover property (irq);
	cover property ($rose(monitor_reset_out));
	cover property (reg_rd_in ##1 reg_rdata_out != 8'h00);
endmodule
bind supply_monitor_control supply_monitor_control_properties #(
	.MIN_PULSE_CNT(MIN_PULSE_CNT)
) i_props (
	.mclk_in, .sys_rst_in, .other_reset_in, .below_threshold_in,
	.comparator_enable_out, .monitor_reset_out,
	.monitor_interrupt_request_out, .reg_addr_in, .reg_rd_in,
	.reg_rdata_out
);

/* bench/tb_top.sv */
// Register-level testbench for the supply monitor control block
`timescale 1ns/1ps
module tb_top;
	import supply_monitor_pkg::*;
	localparam int PULSE = 8;
	logic clk, rst, orst, opt, wen, ren, bop, mrst, cen, irq, below;
	logic [2:0] bsel;
	logic [3:0] lvl;
	logic [4:0] sup;
	logic [7:0] wdat, rdat;
	logic [15:0] addr;
	int fail_count = 0;
	int checks_done = 0;
	int n;
	supply_monitor_control #(.MIN_PULSE_CNT(PULSE)) i_supply_monitor_control (
		.mclk_in(clk), .sys_rst_in(rst), .other_reset_in(orst),
		.default_start_option_in(opt), .monitor_reset_out(mrst),
		.below_threshold_in(below), .comparator_enable_out(cen),
		.level_code_out(lvl), .monitor_interrupt_request_out(irq),
		.reg_addr_in(addr), .reg_wr_in(wen), .reg_bit_op_in(bop),
		.reg_bit_sel_in(bsel), .reg_wdata_in(wdat), .reg_rd_in(ren),
		.reg_rdata_out(rdat)
	);
	supply_comparator_model i_supply_comparator_model (
		.enable_in(cen), .level_in(lvl), .supply_in(sup), .below_out(below)
	);
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task automatic check(input string what, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input logic b = 0, input logic [2:0] s = 0);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		bop <= b;
		bsel <= s;
		wen <= 1;
		@(posedge clk);
		wen <= 0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e, string w);
		@(posedge clk);
		addr <= a;
		ren <= 1;
		@(posedge clk);
		ren <= 0;
		#1 check(w, rdat, e);
	endtask
	task automatic set_sup(input logic [4:0] v);
		@(posedge clk);
		sup <= v;
	endtask
	// Bounded wait on the interrupt (w = 0) or the reset request (w = 1)
	task automatic wait_for(input bit w, input logic v, output int k);
		for (k = 1; k <= 300; k++) begin
			@(posedge clk);
			#1;
			if ((w ? mrst : irq) === v)
				return;
		end
		fail_count++;
		finish_test();
	endtask
	initial begin
		{rst, orst, opt, wen, ren, bop, bsel, sup, wdat, addr} = '0;
		rst = 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		rd(CTRL_ADDR, 8'h00, "ctrl reset");
		rd(LEVEL_ADDR, 8'h00, "level reset");
		rd(16'h0000, 8'h00, "unmapped");
		wr(LEVEL_ADDR, 8'h05);
		wr(LEVEL_ADDR, 8'h01, 1, 3'h3);
		wr(LEVEL_ADDR, 8'h00, 1, 3'h0);
		rd(LEVEL_ADDR, 8'h0c, "level bits");
		wr(CTRL_ADDR, 8'h03);
		rd(CTRL_ADDR, 8'h02, "mode bit");
		wr(CTRL_ADDR, 8'h80);
		repeat (2) @(posedge clk);
		#1 check("comparator on", cen, 1);
		check("level code", lvl, 8'h0c);
		// Equal to threshold must stay quiet
		set_sup(5'h0c);
		rd(CTRL_ADDR, 8'h80, "at threshold");
		set_sup(5'h0d);
		wait_for(0, 1, n);
		check("low delay", n >= PULSE && n <= PULSE + 8, 1);
		rd(CTRL_ADDR, 8'h81, "flag low");
		set_sup(5'h00);
		wait_for(0, 1, n);
		rd(CTRL_ADDR, 8'h80, "flag high");
		set_sup(5'h0d);
		wait_for(0, 1, n);
		wr(CTRL_ADDR, 8'h00, 1, 3'h7);
		wait_for(0, 1, n);
		rd(CTRL_ADDR, 8'h00, "stopped");
		set_sup(5'h00);
		wr(LEVEL_ADDR, 8'h03);
		wr(CTRL_ADDR, 8'h82);
		set_sup(5'h04);
		wait_for(1, 1, n);
		check("reset delay", n >= PULSE && n <= PULSE + 8, 1);
		repeat (3) @(posedge clk);
		#1 check("reset held", mrst, 1);
		set_sup(5'h00);
		wait_for(1, 0, n);
		rd(CTRL_ADDR, 8'h82, "ctrl kept");
		rd(LEVEL_ADDR, 8'h03, "level kept");
		rd(CAUSE_ADDR, 8'h01, "cause set");
		rd(CAUSE_ADDR, 8'h00, "cause read clear");
		@(posedge clk);
		orst <= 1;
		@(posedge clk);
		orst <= 0;
		rd(CTRL_ADDR, 8'h00, "ctrl other");
		rd(LEVEL_ADDR, 8'h00, "level other");
		wr(LEVEL_ADDR, 8'h05);
		@(posedge clk);
		opt <= 1;
		repeat (4) @(posedge clk);
		#1 check("start code", lvl, 8'h0f);
		check("start on", cen, 1);
		set_sup(5'h10);
		wait_for(1, 1, n);
		set_sup(5'h00);
		wait_for(1, 0, n);
		rd(LEVEL_ADDR, 8'h00, "level start");
		rd(CTRL_ADDR, 8'h00, "ctrl start");
		finish_test();
	end
endmodule
